// [uecfg_top.sv]
/*
  Endpoint configuration and status register file for endpoints 1 to 7,
  with command decode, token gating and a maskable interrupt.
  Assumes an AHB-Lite master on mclk and a link engine on mclk that gives
  token, data toggle and fault pulses without synchronisation.
*/
// The register addresses and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// [R1] A writable bit per endpoint picks single buffering at 0 and double buffering at 1.
// [R2] A writable bit per endpoint routes its FIFO over the shared bus at 0, direct path at 1.
// [R3] A read-only two-bit field shows the current data toggle: DATA0, DATA1, DATA2, MDATA.
// [R4] A read-only three-bit field shows ready 000, error 010, stall 011 or invalid 111.
// [R5] The endpoint reinit command returns that endpoint's condition to ready.
// [R6] A receive error or transmit timeout sets error, except while stall or invalid shows.
// [R7] The endpoint halt command sets that endpoint's condition to stall.
// [R8] A read-only blocked bit is 1 when transfers are refused, and tokens then get NAK.
// [R9] A writable direction bit selects OUT at 0 and IN at 1.
// [R10] A writable two-bit field selects control, isochronous, bulk or interrupt transfers.
// [R11] A writable two-bit field gives one, two or three isochronous transactions per frame.
// [R12] Software programs the register while handling set-configuration and set-interface.
// [R13] Odd endpoints are IN and take only direction 1; even endpoints are OUT, only 0.
// [R14] Software selects the direct path before it starts any bus-master transfer.
// [R15] Writes to read-only fields are ignored and reserved bits change nothing.
module uecfg_top #(
  parameter int unsigned NUM_EP    = uecfg_pkg::NUM_EP,
  parameter logic [6:0]  VALID_EPS = 7'h7F
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic [31:0]              hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                token_valid,
  input  wire logic [2:0]          token_ep,
  output logic                     token_nak,
  output logic                     token_pass,
  input  wire logic [NUM_EP-1:0]   rx_data_error,
  input  wire logic [NUM_EP-1:0]   tx_timeout,
  input  wire logic [2*NUM_EP-1:0] toggle_state,
  output logic [NUM_EP-1:0]        ep_dual_packet,
  output logic [NUM_EP-1:0]        ep_direct_path,
  output logic [NUM_EP-1:0]        ep_dir_in,
  output logic [2*NUM_EP-1:0]      ep_transfer_type,
  output logic [2*NUM_EP-1:0]      iso_transactions_per_frame,
  output logic [NUM_EP-1:0]        ep_blocked,
  output logic                     irq
);
  uecfg_regbus_if rb ();

  logic [31:0]         slave_rdata;
  logic                slave_ready;

  // Per-endpoint software fields.
  logic [NUM_EP-1:0]   pkt_mode;
  logic [NUM_EP-1:0]   bus_sel;
  logic [NUM_EP-1:0]   dir;
  logic [1:0]          t_type   [NUM_EP];
  logic [1:0]          iso_per  [NUM_EP];

  // Per-endpoint hardware state.
  logic [2:0]          cond     [NUM_EP];
  logic [NUM_EP-1:0]   blocked;
  logic [NUM_EP-1:0]   err_evt;
  logic [NUM_EP-1:0]   reinit_pulse;
  logic [NUM_EP-1:0]   halt_pulse;

  // Interrupt registers.
  logic [7:0]          irq_status;
  logic [7:0]          irq_mask;
  logic [7:0]          irq_set;
  logic [7:0]          irq_clr;
  logic                nak_evt;

  logic                cmd_write;
  logic [2:0]          cmd_ep;
  logic [3:0]          cmd_op;

  // Endpoint number 1..NUM_EP addressed by a byte offset, or 0 when none.
  function automatic logic [2:0] ep_of_addr(input logic [7:0] a);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < NUM_EP; i++) begin
      if (a == uecfg_pkg::EP_BASE + 8'(4 * i)) begin
        n = 3'(i + 1);
      end
    end
    return n;
  endfunction

  // Direction fixed by the endpoint's parity: odd endpoints are IN.
  function automatic logic fixed_dir(input int unsigned idx);
    return ((idx + 1) % 2) == 1;                                     // [R13]
  endfunction

  uecfg_ahb_slave u_slave (
    .mclk      (mclk),
    .reset     (reset),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hwdata    (hwdata),
    .hready    (hready),
    .hrdata    (slave_rdata),
    .hreadyout (slave_ready),
    .rb        (rb.slave_side)
  );

  // Bus outputs already leave flip-flops inside the slave.
  assign hrdata    = slave_rdata;
  assign hreadyout = slave_ready;

  always_ff @(posedge mclk) begin
    if (reset) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Command register decode; hsize is not checked since only words are used.
  assign cmd_write = rb.wr_en && (rb.wr_addr == uecfg_pkg::CMD_OFFSET);
  assign cmd_ep    = rb.wr_data[uecfg_pkg::CMD_EP_LSB +: 3];
  assign cmd_op    = rb.wr_data[3:0];

  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : g_ep
      logic cfg_write;

      assign cfg_write = rb.wr_en && (ep_of_addr(rb.wr_addr) == 3'(g + 1));

      assign reinit_pulse[g] = cmd_write && (cmd_ep == 3'(g + 1)) &&
                               (cmd_op == uecfg_pkg::CMD_REINIT);    // [R5]
      assign halt_pulse[g]   = cmd_write && (cmd_ep == 3'(g + 1)) &&
                               (cmd_op == uecfg_pkg::CMD_HALT);      // [R7]

      // Only the writable fields take the bus data; the rest is discarded.
      always_ff @(posedge mclk) begin
        if (reset) begin
          pkt_mode[g] <= uecfg_pkg::ENDPOINT_REINIT_COMMAND[uecfg_pkg::PKT_MODE_BIT];
          bus_sel[g]  <= uecfg_pkg::ENDPOINT_REINIT_COMMAND[uecfg_pkg::BUS_SEL_BIT];
          t_type[g]   <= uecfg_pkg::ENDPOINT_REINIT_COMMAND[uecfg_pkg::TTYPE_LSB +: 2];
          iso_per[g]  <= uecfg_pkg::ENDPOINT_REINIT_COMMAND[uecfg_pkg::ISO_LSB +: 2];
        end else if (cfg_write) begin                                // [R15]
          pkt_mode[g] <= rb.wr_data[uecfg_pkg::PKT_MODE_BIT];        // [R1]
          bus_sel[g]  <= rb.wr_data[uecfg_pkg::BUS_SEL_BIT];         // [R2]
          t_type[g]   <= rb.wr_data[uecfg_pkg::TTYPE_LSB +: 2];      // [R10]
          iso_per[g]  <= rb.wr_data[uecfg_pkg::ISO_LSB +: 2];        // [R11]
        end
      end

      // A direction against the endpoint's fixed one is refused.
      always_ff @(posedge mclk) begin
        if (reset) begin
          dir[g] <= uecfg_pkg::ENDPOINT_REINIT_COMMAND[uecfg_pkg::DIR_BIT];
        end else if (cfg_write &&
                     rb.wr_data[uecfg_pkg::DIR_BIT] == fixed_dir(g)) begin
          dir[g] <= rb.wr_data[uecfg_pkg::DIR_BIT];                  // [R9] [R13]
        end
      end

      uecfg_ep_cond u_cond (
        .mclk        (mclk),
        .reset       (reset),
        .ep_valid    (VALID_EPS[g]),
        .reinit_cmd  (reinit_pulse[g]),
        .halt_cmd    (halt_pulse[g]),
        .rx_error    (rx_data_error[g]),
        .tx_timeout  (tx_timeout[g]),
        .cond        (cond[g]),
        .error_event (err_evt[g])
      );

      // Transfers are refused while the endpoint is invalid, stalled, or
      // its direction is not yet set to the fixed one.
      assign blocked[g] = (cond[g] == uecfg_pkg::COND_INVALID) ||
                          (cond[g] == uecfg_pkg::COND_STALL) ||
                          (dir[g] != fixed_dir(g));                  // [R8]

      always_ff @(posedge mclk) begin
        if (reset) begin
          ep_dual_packet[g]                 <= 1'b0;
          ep_direct_path[g]                 <= 1'b0;
          ep_dir_in[g]                      <= 1'b0;
          ep_transfer_type[2*g +: 2]        <= 2'h0;
          iso_transactions_per_frame[2*g +: 2] <= 2'h0;
          ep_blocked[g]                     <= 1'b1;
        end else begin
          ep_dual_packet[g]                 <= pkt_mode[g];          // [R1]
          ep_direct_path[g]                 <= bus_sel[g];           // [R2]
          ep_dir_in[g]                      <= dir[g];               // [R9]
          ep_transfer_type[2*g +: 2]        <= t_type[g];            // [R10]
          iso_transactions_per_frame[2*g +: 2] <= iso_per[g];        // [R11]
          ep_blocked[g]                     <= blocked[g];           // [R8]
        end
      end
    end
  endgenerate

  // Token gating: a blocked or unknown endpoint is answered with NAK.
  always_ff @(posedge mclk) begin
    if (reset) begin
      token_nak  <= 1'b0;
      token_pass <= 1'b0;
    end else begin
      token_nak  <= nak_evt;                                         // [R8]
      token_pass <= token_valid && !nak_evt;
    end
  end

  always_comb begin
    nak_evt = 1'b0;
    if (token_valid) begin
      nak_evt = 1'b1;
      for (int i = 0; i < NUM_EP; i++) begin
        if (token_ep == 3'(i + 1) && !blocked[i]) begin
          nak_evt = 1'b0;
        end
      end
    end
  end

  // Interrupt status: sticky, write one to clear, a new event wins.
  assign irq_set = {nak_evt, 7'(err_evt)};
  assign irq_clr = (rb.wr_en && rb.wr_addr == uecfg_pkg::IRQ_STATUS) ?
                   rb.wr_data[7:0] : 8'h00;

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= uecfg_pkg::IRQ_RESET;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask <= uecfg_pkg::IRQ_RESET;
    end else if (rb.wr_en && rb.wr_addr == uecfg_pkg::IRQ_MASK) begin
      irq_mask <= rb.wr_data[7:0];
    end
  end

  // The output is taken from the next status, so it changes on the same edge as the status and stays a flop.
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

  // Read mux; reserved bits and unmapped offsets read as zero.
  always_comb begin
    logic [2:0] n;
    n          = ep_of_addr(rb.rd_addr);
    rb.rd_data = 32'h0000_0000;
    if (n != 3'h0) begin
      for (int i = 0; i < NUM_EP; i++) begin
        if (n == 3'(i + 1)) begin
          rb.rd_data[uecfg_pkg::PKT_MODE_BIT]    = pkt_mode[i];       // [R1]
          rb.rd_data[uecfg_pkg::BUS_SEL_BIT]     = bus_sel[i];        // [R2]
          rb.rd_data[uecfg_pkg::TOGGLE_LSB +: 2] = toggle_state[2*i +: 2]; // [R3]
          rb.rd_data[uecfg_pkg::COND_LSB +: 3]   = cond[i];           // [R4]
          rb.rd_data[uecfg_pkg::BLOCKED_BIT]     = blocked[i];        // [R8]
          rb.rd_data[uecfg_pkg::DIR_BIT]         = dir[i];            // [R9]
          rb.rd_data[uecfg_pkg::TTYPE_LSB +: 2]  = t_type[i];         // [R10]
          rb.rd_data[uecfg_pkg::ISO_LSB +: 2]    = iso_per[i];        // [R11]
        end
      end
    end else if (rb.rd_addr == uecfg_pkg::IRQ_STATUS) begin
      rb.rd_data[7:0] = irq_status;
    end else if (rb.rd_addr == uecfg_pkg::IRQ_MASK) begin
      rb.rd_data[7:0] = irq_mask;
    end
  end
endmodule

// [uecfg_pkg.sv]
/*
  Shared constants of the endpoint configuration and status block: register
  offsets, field positions, condition codes and command codes.
  Assumes a 32-bit AHB-Lite register bus and endpoints numbered 1 to 7.
*/
package uecfg_pkg;
  localparam int unsigned NUM_EP = 7;

  // Byte offsets of the registers; endpoint n sits at EP_BASE + 4 * (n - 1).
  localparam logic [7:0] EP_BASE       = 8'h00;
  localparam logic [7:0] CMD_OFFSET    = 8'h20;
  localparam logic [7:0] IRQ_STATUS    = 8'h24;
  localparam logic [7:0] IRQ_MASK      = 8'h28;
  localparam logic [7:0] ADDR_MASK     = 8'hFF;

  // Field positions of endpoint_status_config.
  localparam int unsigned PKT_MODE_BIT = 15;
  localparam int unsigned BUS_SEL_BIT  = 14;
  localparam int unsigned TOGGLE_LSB   = 12;
  localparam int unsigned COND_LSB     = 9;
  localparam int unsigned BLOCKED_BIT  = 8;
  localparam int unsigned DIR_BIT      = 7;
  localparam int unsigned TTYPE_LSB    = 2;
  localparam int unsigned ISO_LSB      = 0;
  localparam logic [31:0] ENDPOINT_REINIT_COMMAND     = 32'h0000_0000;

  // Condition codes; the remaining codes are reserved.
  localparam logic [2:0] COND_READY    = 3'h0;
  localparam logic [2:0] COND_ERROR    = 3'h2;
  localparam logic [2:0] COND_STALL    = 3'h3;
  localparam logic [2:0] COND_INVALID  = 3'h7;

  // command_register layout: endpoint number in [6:4], opcode in [3:0].
  localparam int unsigned CMD_EP_LSB   = 4;
  localparam logic [3:0] CMD_REINIT    = 4'h1;
  localparam logic [3:0] CMD_HALT      = 4'h2;

  // Interrupt status: bits 0..6 error on endpoint 1..7, bit 7 token refused.
  localparam int unsigned IRQ_NAK_BIT  = 7;
  localparam logic [7:0] IRQ_RESET     = 8'h00;

  typedef enum logic [3:0] {
    COND_S_READY   = 4'b0001,
    COND_S_ERROR   = 4'b0010,
    COND_S_STALL   = 4'b0100,
    COND_S_INVALID = 4'b1000
  } uecfg_cond_t;
endpackage

// [uecfg_regbus_if.sv]
/*
  Internal register port between the bus slave and the register file.
  Assumes both ends run on mclk; rdata is combinational from the register file.
*/
`timescale 1ns/1ps
interface uecfg_regbus_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;

  modport slave_side (output wr_en, output wr_addr, output wr_data, output rd_addr,
                      input rd_data);
  modport file_side  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                      output rd_data);
endinterface

// [uecfg_ahb_slave.sv]
/*
  AHB-Lite slave front end: zero-wait writes, one-wait reads, OKAY always.
  Assumes a single master, single transfers of whole words, and hready fed
  back from this slave's hreadyout.
*/
`timescale 1ns/1ps
module uecfg_ahb_slave (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  uecfg_regbus_if.slave_side rb
);
  logic       accept;
  logic       wr_pending;
  logic       rd_pending;
  logic [7:0] addr_q;

  assign accept = hsel && htrans[1] && hready;

  always_ff @(posedge mclk) begin
    if (reset) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      addr_q     <= 8'h00;
    end else begin
      wr_pending <= accept && hwrite;
      rd_pending <= accept && !hwrite;
      if (accept) begin
        addr_q <= haddr[7:0] & uecfg_pkg::ADDR_MASK;
      end
    end
  end

  // Reads wait one cycle so a write in the preceding data phase is visible.
  always_ff @(posedge mclk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
    end else if (rd_pending) begin
      hreadyout <= 1'b1;
      hrdata    <= rb.rd_data;
    end else if (accept && !hwrite) begin
      hreadyout <= 1'b0;
    end
  end

  assign rb.wr_en   = wr_pending;
  assign rb.wr_addr = addr_q;
  assign rb.wr_data = hwdata;
  assign rb.rd_addr = addr_q;
endmodule

// [uecfg_ep_cond.sv]
/*
  Condition tracker of one endpoint: ready, error, stall or invalid.
  Assumes single-cycle command and event pulses on mclk.
*/
`timescale 1ns/1ps
module uecfg_ep_cond (
  input  wire logic  mclk,
  input  wire logic  reset,
  input  wire logic  ep_valid,
  input  wire logic  reinit_cmd,
  input  wire logic  halt_cmd,
  input  wire logic  rx_error,
  input  wire logic  tx_timeout,
  output logic [2:0] cond,
  output logic       error_event
);
  uecfg_pkg::uecfg_cond_t state;
  uecfg_pkg::uecfg_cond_t next_state;
  logic                   fault;

  assign fault = rx_error || tx_timeout;

  always_comb begin
    next_state = state;
    if (!ep_valid) begin
      next_state = uecfg_pkg::COND_S_INVALID;
    end else begin
      unique case (state)
        uecfg_pkg::COND_S_READY, uecfg_pkg::COND_S_ERROR: begin
          if (halt_cmd) begin
            next_state = uecfg_pkg::COND_S_STALL;             // [R7]
          end else if (reinit_cmd) begin
            next_state = uecfg_pkg::COND_S_READY;             // [R5]
          end else if (fault) begin
            next_state = uecfg_pkg::COND_S_ERROR;             // [R6]
          end
        end
        uecfg_pkg::COND_S_STALL: begin
          if (reinit_cmd) begin
            next_state = uecfg_pkg::COND_S_READY;             // [R5]
          end
        end
        uecfg_pkg::COND_S_INVALID: begin
          next_state = uecfg_pkg::COND_S_INVALID;
        end
        default: begin
          next_state = uecfg_pkg::COND_S_INVALID;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= uecfg_pkg::COND_S_READY;
    end else begin
      state <= next_state;
    end
  end

  // Stall and invalid hold their code; a fault then raises nothing.
  assign error_event = fault && ep_valid && !halt_cmd && !reinit_cmd &&
                       (state == uecfg_pkg::COND_S_READY ||
                        state == uecfg_pkg::COND_S_ERROR);           // [R6]

  always_comb begin
    unique case (state)
      uecfg_pkg::COND_S_READY:   cond = uecfg_pkg::COND_READY;
      uecfg_pkg::COND_S_ERROR:   cond = uecfg_pkg::COND_ERROR;
      uecfg_pkg::COND_S_STALL:   cond = uecfg_pkg::COND_STALL;
      uecfg_pkg::COND_S_INVALID: cond = uecfg_pkg::COND_INVALID;
      default:                   cond = uecfg_pkg::COND_INVALID;
    endcase
  end
endmodule

// [uecfg_props.sv]
/*
  Concurrent checks on the ports of uecfg_top, bound into every instance.
  Assumes one clock, hready fed back from hreadyout, all endpoints valid.
*/
`timescale 1ns/1ps
module uecfg_props #(
  parameter int unsigned NUM_EP = 7
) (
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic                hsel,
  input wire logic [31:0]         haddr,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic [31:0]         hwdata,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic                token_valid,
  input wire logic [2:0]          token_ep,
  input wire logic                token_nak,
  input wire logic                token_pass,
  input wire logic [NUM_EP-1:0]   ep_dual_packet,
  input wire logic [NUM_EP-1:0]   ep_direct_path,
  input wire logic [NUM_EP-1:0]   ep_dir_in,
  input wire logic [2*NUM_EP-1:0] ep_transfer_type,
  input wire logic [2*NUM_EP-1:0] iso_transactions_per_frame,
  input wire logic [NUM_EP-1:0]   ep_blocked
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  logic [2:0] last_ep;
  always_ff @(posedge mclk) begin
    last_ep <= token_ep;
  end
  sequence s_addr(logic w, logic [7:0] a);
    hsel && htrans == 2'b10 && hready && hwrite == w && haddr[7:0] == a;
  endsequence
  sequence s_cmd(logic [6:0] c);
    s_addr(1'b1, 8'h20) ##1 hwdata[6:0] == c;
  endsequence
  a_read_wait: assert property (hsel && htrans[1] && !hwrite && hready
    |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
  a_write_nowait: assert property (hsel && htrans[1] && hwrite && hready |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response seen");
  a_cfg_write: assert property (s_addr(1'b1, 8'h00) |-> ##3
    (ep_dual_packet[0] == $past(hwdata[15], 2) && ep_direct_path[0] == $past(hwdata[14], 2)
     && ep_transfer_type[1:0] == $past(hwdata[3:2], 2)
     && iso_transactions_per_frame[1:0] == $past(hwdata[1:0], 2)))
    else $error("endpoint 1 settings not applied");
  a_even_dir: assert property ((ep_dir_in & 7'h2A) == 7'h00)
    else $error("even endpoint set to IN");
  a_odd_blocked: assert property ((~ep_dir_in & ~ep_blocked & 7'h55) == 7'h00)
    else $error("odd endpoint open with direction OUT");
  a_token_answer: assert property (token_valid |=> token_nak != token_pass)
    else $error("token not answered once");
  a_ep0_nak: assert property (token_valid && token_ep == 3'h0 |=> token_nak)
    else $error("unknown endpoint not refused");
  a_nak_blocked: assert property ($past(token_valid) && last_ep != 3'h0
    && ep_blocked[last_ep - 3'h1] |-> token_nak) else $error("blocked endpoint passed");
  a_pass_open: assert property ($past(token_valid) && last_ep != 3'h0
    && !ep_blocked[last_ep - 3'h1] |-> token_pass) else $error("open endpoint refused");
  a_halt_stall: assert property (s_cmd(7'h22) |-> ##[1:3] ep_blocked[1])
    else $error("halt did not block");
  a_reinit_ready: assert property (s_cmd(7'h21) |-> ##[1:3] !ep_blocked[1])
    else $error("reinit did not unblock");
endmodule
bind uecfg_top uecfg_props #(.NUM_EP(NUM_EP)) u_props (.mclk(mclk), .reset(reset),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .token_valid(token_valid),
  .token_ep(token_ep), .token_nak(token_nak), .token_pass(token_pass),
  .ep_dual_packet(ep_dual_packet), .ep_direct_path(ep_direct_path),
  .ep_dir_in(ep_dir_in), .ep_transfer_type(ep_transfer_type),
  .iso_transactions_per_frame(iso_transactions_per_frame), .ep_blocked(ep_blocked));

// [uecfg_host_model.sv]
/*
  Far side model: the link engine serving the USB host, giving tokens,
  packet faults and data toggles. Assumes answers one edge after a token.
*/
`timescale 1ns/1ps
module uecfg_host_model (
  input  wire logic  mclk,
  input  wire logic  token_nak,
  input  wire logic  token_pass,
  output logic       token_valid,
  output logic [2:0] token_ep,
  output logic [6:0] rx_data_error,
  output logic [6:0] tx_timeout,
  output logic [13:0] toggle_state
);
  initial begin
    token_valid   = 1'b0;
    token_ep      = 3'h5;
    rx_data_error = 7'h00;
    tx_timeout    = 7'h00;
    toggle_state  = 14'h0000;
  end
  // The endpoint number is scrambled between tokens so a stale value never passes.
  task automatic token(input logic [2:0] ep, output logic nak, output logic pass);
    @(posedge mclk);
    token_valid <= 1'b1;
    token_ep    <= ep;
    @(posedge mclk);
    token_valid <= 1'b0;
    token_ep    <= ~ep;
    @(posedge mclk);
    // The answer stands one cycle only, so it is read before this edge's update.
    nak  = token_nak;
    pass = token_pass;
  endtask
  task automatic fault(input logic [6:0] rx, input logic [6:0] tx);
    @(posedge mclk);
    rx_data_error <= rx;
    tx_timeout    <= tx;
    @(posedge mclk);
    rx_data_error <= 7'h00;
    tx_timeout    <= 7'h00;
  endtask
  task automatic set_toggle(input logic [13:0] t);
    @(posedge mclk);
    toggle_state <= t;
  endtask
endmodule

// [uecfg_top_tb.sv]
/*
  Self-checking bench of uecfg_top: AHB-Lite register tasks and scenarios.
  Assumes uecfg_host_model drives the link side and the checker is bound.
*/
`timescale 1ns/1ps
module uecfg_top_tb;
  logic        mclk, reset, hsel, hwrite, hreadyout, hresp, irq, nak, pass;
  logic        token_valid, token_nak, token_pass;
  logic [31:0] haddr, hwdata, hrdata, rd, d, e;
  logic [1:0]  htrans, t, i, tg;
  logic [2:0]  token_ep;
  logic [6:0]  rxe, txo, dual, direct, dir_in, blocked;
  logic [13:0] tgs, ttype, iso;
  int          n_errors, total_checks, cycles, n;

  uecfg_top dut (.mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .token_valid(token_valid), .token_ep(token_ep),
    .token_nak(token_nak), .token_pass(token_pass), .rx_data_error(rxe), .tx_timeout(txo),
    .toggle_state(tgs), .ep_dual_packet(dual), .ep_direct_path(direct), .ep_dir_in(dir_in),
    .ep_transfer_type(ttype), .iso_transactions_per_frame(iso), .ep_blocked(blocked),
    .irq(irq));
  uecfg_host_model host (.mclk(mclk), .token_nak(token_nak), .token_pass(token_pass),
    .token_valid(token_valid), .token_ep(token_ep), .rx_data_error(rxe), .tx_timeout(txo),
    .toggle_state(tgs));

  task automatic summarize();
    if (n_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
    total_checks++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= 1'b1;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= v;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'b10; hwrite <= 1'b0; hwdata <= ~hwdata;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  function automatic logic [7:0] epa(input int k);
    return uecfg_pkg::EP_BASE + 8'(4 * (k - 1));
  endfunction
  function automatic logic [31:0] cmd(input int k, input logic [3:0] op);
    return {25'h0, 3'(k), op};
  endfunction

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial cycles = 0;
  // A stuck handshake would otherwise hang the run, so cycles are capped.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end

  initial begin
    reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hwdata = 32'h0; n_errors = 0; total_checks = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    for (n = 1; n <= 7; n++) begin
      rdr(epa(n), rd);
      chk(rd, n % 2 ? 32'h0000_0100 : 32'h0, "reset value");
    end
    host.set_toggle(14'b10_01_00_11_10_01_00);
    for (n = 1; n <= 7; n++) begin
      t = 2'(n - 1); i = 2'((n - 1) % 3); tg = 2'(n - 1);
      d = {16'hFFFF, 2'b11, 2'b11, 3'b111, 1'b1, n[0], 3'b111, t, i};
      e = {16'h0, 2'b11, tg, 4'b0000, n[0], 3'b000, t, i};
      wr(epa(n), d);
      rdr(epa(n), rd);
      chk(rd, e, "endpoint word");
      chk({dual[n-1], direct[n-1], dir_in[n-1], ttype[2*n-2 +: 2], iso[2*n-2 +: 2],
           blocked[n-1]}, {2'b11, n[0], t, i, 1'b0}, "endpoint outputs");
    end
    for (n = 1; n <= 2; n++) begin
      wr(epa(n), {24'h0, ~n[0], 7'b0001000});
      rdr(epa(n), rd);
      chk(rd, {18'h0, 2'(n - 1), 4'h0, n[0], 7'b0001000}, "fixed direction");
    end
    for (n = 0; n <= 7; n++) begin
      host.token(3'(n), nak, pass);
      chk({nak, pass}, n == 0 ? 2'b10 : 2'b01, "token answer");
    end
    wr(uecfg_pkg::IRQ_MASK, 32'h0);
    wr(uecfg_pkg::CMD_OFFSET, cmd(2, uecfg_pkg::CMD_HALT));
    rdr(epa(2), rd);
    chk(rd[11:8], 4'b0111, "halt");
    host.token(3'h2, nak, pass);
    chk({nak, pass}, 2'b10, "stalled token");
    host.fault(7'h02, 7'h02);
    rdr(epa(2), rd);
    chk(rd[11:8], 4'b0111, "fault in stall");
    wr(uecfg_pkg::CMD_OFFSET, cmd(2, uecfg_pkg::CMD_REINIT));
    rdr(epa(2), rd);
    chk(rd[11:8], 4'b0000, "reinit");
    host.fault(7'h02, 7'h00);
    host.fault(7'h00, 7'h04);
    rdr(epa(2), rd);
    chk(rd[11:8], 4'b0100, "receive error");
    rdr(epa(3), rd);
    chk(rd[11:8], 4'b0100, "transmit timeout");
    rdr(uecfg_pkg::IRQ_STATUS, rd);
    chk({rd[30:0], irq}, {31'h86, 1'b0}, "masked status");
    wr(uecfg_pkg::IRQ_MASK, 32'h02);
    rdr(uecfg_pkg::IRQ_MASK, rd);
    chk({rd[30:0], irq}, {31'h02, 1'b1}, "unmasked irq");
    wr(uecfg_pkg::CMD_OFFSET, cmd(2, uecfg_pkg::CMD_HALT));
    rdr(epa(2), rd);
    chk(rd[11:8], 4'b0111, "halt from error");
    wr(uecfg_pkg::CMD_OFFSET, cmd(2, uecfg_pkg::CMD_REINIT));
    wr(uecfg_pkg::IRQ_STATUS, 32'h02);
    rdr(uecfg_pkg::IRQ_STATUS, rd);
    chk({rd[30:0], irq}, {31'h84, 1'b0}, "status clear");
    wr(uecfg_pkg::IRQ_STATUS, 32'hFF);
    wr(8'h40, 32'hFFFF_FFFF);
    rdr(8'h40, rd);
    chk(rd, 32'h0, "unmapped");
    rdr(uecfg_pkg::CMD_OFFSET, rd);
    chk(rd, 32'h0, "command readback");
    rdr(uecfg_pkg::IRQ_STATUS, rd);
    chk(rd, 32'h0, "status empty");
    summarize();
  end
endmodule
